// File: design/tm2_timer.sv
/*
 * Third 16-bit timer/counter with capture, auto-reload (up or down) and
 * baud-rate generator modes, plus clock-out on the count pin.
 * Assumes the core drives one special-function access per cycle on ref_clk,
 * that count and trigger pins are asynchronous, and that the timer 1
 * overflow pulse comes from logic on ref_clk.
 */
//
// Behaviour
// - Count is low and high byte registers.
// - Timer function counts once per machine cycle.
// - Counter samples pin, counts on high-then-low.
// - Edge count appears at next cycle S3P1.
// - Control bits select reload, capture, baud, off.
// - Run bit starts and stops counting.
// - Source select picks timer or pin counting.
// - Overflow sets flag bit 7; software clears.
// - No overflow flag while serial clock selected.
// - Trigger edge with enable sets external flag.
// - External flag requests interrupt, not up/down.
// - Receive select routes overflows to receiver.
// - Transmit select routes overflows to transmitter.
// - External enable gates trigger edges, not baud.
// - Reload on overflow or trigger; capture alternative.
// - Serial clock mode forces reload, ignores capture.
// - Capture copies count into capture/reload pair.
// - Up-count overflow loads capture/reload pair.
// - Down enable resets zero; trigger sets direction.
`timescale 1ns/1ps
module tm2_timer
    import tm2_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input tm2_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic count_pin_i,
    output logic count_pin_o,
    output logic count_pin_oe,
    input wire logic trigger_pin_i,
    input wire logic timer1_ovf,
    output logic timer_irq,
    output logic rx_clk_pulse,
    output logic tx_clk_pulse
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------

    function automatic logic tm2_wr_hit(input tm2_sfr_req_type r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : tm2_wr_hit

    tm2_phase_type ph;
    tm2_ctrl_type ctrl_q, ctrl_d;
    logic [TM2_MODE_WIDTH-1:0] mode_q, mode_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] rcap_q, rcap_d;
    logic cp_s1_q, cp_s2_q, tp_s1_q, tp_s2_q;
    logic cp_smp_q, cp_smp_d, tp_smp_q, tp_smp_d;
    logic cp_fall_q, cp_fall_d, tp_fall_q, tp_fall_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d, rx_q, rx_d, tx_q, tx_d, ck_q, ck_d, ckoe_q, ckoe_d;
    logic ctrl_wr, mode_wr, rlo_wr, rhi_wr, clo_wr, chi_wr;
    logic baud, down_count_enable, down_count_enable_act, ckout_act, up, tick, inc_en;
    logic ovf_evt, unf_evt, roll_evt, trig_evt, cap_evt, reload_trig;

    tm2_phase_gen u_phase (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .phase(ph)
    );

    assign ctrl_wr = tm2_wr_hit(sfr_req, TM2_ADDR_CTRL);
    assign mode_wr = tm2_wr_hit(sfr_req, TM2_ADDR_MODE);
    assign rlo_wr = tm2_wr_hit(sfr_req, TM2_ADDR_RCAP_LO);
    assign rhi_wr = tm2_wr_hit(sfr_req, TM2_ADDR_RCAP_HI);
    assign clo_wr = tm2_wr_hit(sfr_req, TM2_ADDR_CNT_LO);
    assign chi_wr = tm2_wr_hit(sfr_req, TM2_ADDR_CNT_HI);

    // ------------------------------------------------------------------
    // Mode selection and count events
    // ------------------------------------------------------------------

    // Either serial select overrides capture select; up/down only in reload.
    assign baud = ctrl_q.rx_clk_sel | ctrl_q.tx_clk_sel;
    assign down_count_enable = mode_q[TM2_MODE_DOWN_COUNT_ENABLE_BIT];
    assign down_count_enable_act = down_count_enable && !baud && !ctrl_q.cap_sel;
    assign ckout_act = mode_q[TM2_MODE_OE_BIT] && !ctrl_q.src_sel;
    assign up = !down_count_enable_act || tp_smp_q;

    // Pin edges land at S3P1; baud and clock-out time at every state time.
    always_comb begin
        if (ctrl_q.src_sel) begin
            tick = ph.update && cp_fall_q;
        end else if (baud || ckout_act) begin
            tick = ph.state;
        end else begin
            tick = ph.update;
        end
    end

    assign inc_en = ctrl_q.run && tick;
    assign ovf_evt = inc_en && up && (cnt_q == TM2_CNT_MAX);
    assign unf_evt = inc_en && !up && (cnt_q == rcap_q);
    assign roll_evt = ovf_evt || unf_evt;
    // The trigger pin is a direction input under up/down counting.
    assign trig_evt = ph.update && tp_fall_q && ctrl_q.ext_enable && !down_count_enable_act;
    assign cap_evt = trig_evt && ctrl_q.cap_sel && !baud;
    assign reload_trig = trig_evt && !ctrl_q.cap_sel && !baud;

    // ------------------------------------------------------------------
    // Pin synchronisers and machine-cycle samples
    // ------------------------------------------------------------------

    // A falling edge is armed at S5P2 and consumed at the next S3P1.
    always_comb begin
        cp_smp_d = cp_smp_q;
        tp_smp_d = tp_smp_q;
        cp_fall_d = cp_fall_q;
        tp_fall_d = tp_fall_q;
        if (ph.sample) begin
            cp_smp_d = cp_s2_q;
            tp_smp_d = tp_s2_q;
            cp_fall_d = cp_smp_q && !cp_s2_q;
            tp_fall_d = tp_smp_q && !tp_s2_q;
        end else if (ph.update) begin
            cp_fall_d = 1'b0;
            tp_fall_d = 1'b0;
        end
    end

    // Samples start high so a pin held low at reset reads as one falling edge.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cp_s1_q <= 1'b1;
            cp_s2_q <= 1'b1;
            tp_s1_q <= 1'b1;
            tp_s2_q <= 1'b1;
            cp_smp_q <= 1'b1;
            tp_smp_q <= 1'b1;
            cp_fall_q <= 1'b0;
            tp_fall_q <= 1'b0;
        end else begin
            cp_s1_q <= count_pin_i;
            cp_s2_q <= cp_s1_q;
            tp_s1_q <= trigger_pin_i;
            tp_s2_q <= tp_s1_q;
            cp_smp_q <= cp_smp_d;
            tp_smp_q <= tp_smp_d;
            cp_fall_q <= cp_fall_d;
            tp_fall_q <= tp_fall_d;
        end
    end

    // ------------------------------------------------------------------
    // Register file, count and capture/reload state
    // ------------------------------------------------------------------

    // Hardware flag sets are applied after the write so an event is never lost.
    always_comb begin
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        rcap_d = rcap_q;
        if (ctrl_wr) begin
            ctrl_d = tm2_ctrl_type'(sfr_req.wdata);
        end
        if (mode_wr) begin
            mode_d = sfr_req.wdata[TM2_MODE_WIDTH-1:0];
        end
        if (rlo_wr) begin
            rcap_d[7:0] = sfr_req.wdata;
        end
        if (rhi_wr) begin
            rcap_d[15:8] = sfr_req.wdata;
        end
        if (cap_evt) begin
            rcap_d = cnt_q;
        end
        if (unf_evt) begin
            cnt_d = TM2_CNT_MAX;
        end else if (ovf_evt) begin
            cnt_d = (baud || !ctrl_q.cap_sel) ? rcap_q : TM2_CNT_ZERO;
        end else if (inc_en) begin
            cnt_d = up ? cnt_q + TM2_CNT_ONE : cnt_q - TM2_CNT_ONE;
        end
        if (reload_trig) begin
            cnt_d = rcap_q;
        end
        if (clo_wr) begin
            cnt_d[7:0] = sfr_req.wdata;
        end
        if (chi_wr) begin
            cnt_d[15:8] = sfr_req.wdata;
        end
        if (roll_evt && !baud && !ckout_act) begin
            ctrl_d.ovf_flag = 1'b1;
        end
        if (roll_evt && down_count_enable_act) begin
            ctrl_d.ext_flag = !ctrl_q.ext_flag;
        end else if (trig_evt) begin
            ctrl_d.ext_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_q <= tm2_ctrl_type'(TM2_CTRL_RESET);
            mode_q <= TM2_MODE_RESET;
            cnt_q <= TM2_CNT_ZERO;
            rcap_q <= TM2_CNT_ZERO;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            rcap_q <= rcap_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data, interrupt, serial clocks and clock-out
    // ------------------------------------------------------------------

    // Unmapped addresses and reserved mode bits read as zero.
    always_comb begin
        rdata_d = TM2_BYTE_ZERO;
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                TM2_ADDR_CTRL: rdata_d = ctrl_q;
                TM2_ADDR_MODE: rdata_d = {6'h00, mode_q};
                TM2_ADDR_RCAP_LO: rdata_d = rcap_q[7:0];
                TM2_ADDR_RCAP_HI: rdata_d = rcap_q[15:8];
                TM2_ADDR_CNT_LO: rdata_d = cnt_q[7:0];
                TM2_ADDR_CNT_HI: rdata_d = cnt_q[15:8];
                default: rdata_d = TM2_BYTE_ZERO;
            endcase
        end
        irq_d = ctrl_q.ovf_flag || (ctrl_q.ext_flag && !down_count_enable);
        rx_d = ctrl_q.rx_clk_sel ? ovf_evt : timer1_ovf;
        tx_d = ctrl_q.tx_clk_sel ? ovf_evt : timer1_ovf;
        ckoe_d = ckout_act;
        ck_d = (ckout_act && ovf_evt) ? !ck_q : ck_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_q <= TM2_BYTE_ZERO;
            irq_q <= 1'b0;
            rx_q <= 1'b0;
            tx_q <= 1'b0;
            ck_q <= 1'b0;
            ckoe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            ck_q <= ck_d;
            ckoe_q <= ckoe_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign timer_irq = irq_q;
    assign rx_clk_pulse = rx_q;
    assign tx_clk_pulse = tx_q;
    assign count_pin_o = ck_q;
    assign count_pin_oe = ckoe_q;

    // ------------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_OVF_SETS_FLAG: assert property (
        ovf_evt && !baud && !ckout_act |=> ctrl_q.ovf_flag)
        else $error("overflow did not set the overflow flag");
    AST_BAUD_NO_FLAG: assert property (
        baud && !ctrl_q.ovf_flag && !ctrl_wr |=> !ctrl_q.ovf_flag)
        else $error("overflow flag set while clocking the serial port");
    AST_RELOAD_ON_OVF: assert property (
        ovf_evt && (baud || !ctrl_q.cap_sel) && !reload_trig && !clo_wr && !chi_wr
        |=> cnt_q == $past(rcap_q))
        else $error("overflow did not reload the count");
    AST_CAPTURE: assert property (
        cap_evt |=> rcap_q == $past(cnt_q))
        else $error("trigger edge did not capture the count");
    AST_EXT_FLAG: assert property (
        trig_evt && !roll_evt |=> ctrl_q.ext_flag)
        else $error("trigger edge did not set the external flag");
    AST_STOPPED: assert property (
        !ctrl_q.run && !reload_trig && !clo_wr && !chi_wr |=> $stable(cnt_q))
        else $error("count moved while the timer was stopped");
    AST_TIMER_RATE: assert property (
        ctrl_q.run && !ctrl_q.src_sel && !baud && !ckout_act && ph.update
        && !reload_trig && !roll_evt && !clo_wr && !chi_wr
        |=> cnt_q == $past(cnt_q) + TM2_CNT_ONE || cnt_q == $past(cnt_q) - TM2_CNT_ONE)
        else $error("timer function missed a machine cycle");
    AST_EDGE_ONLY: assert property (
        ctrl_q.src_sel && !cp_fall_q && !reload_trig && !clo_wr && !chi_wr
        |=> $stable(cnt_q))
        else $error("counter moved without a pin falling edge");
    AST_IRQ: assert property (
        ##1 timer_irq == $past(ctrl_q.ovf_flag || (ctrl_q.ext_flag && !down_count_enable)))
        else $error("interrupt request does not follow the flags");
    AST_RX_ROUTE: assert property (
        ctrl_q.rx_clk_sel && ovf_evt |=> rx_clk_pulse)
        else $error("receive clock missed a timer overflow");

    COV_CAPTURE: cover property (cap_evt);
    COV_RELOAD_TRIG: cover property (reload_trig);
    COV_BAUD_OVF: cover property (baud && ovf_evt);
    COV_UNDERFLOW: cover property (unf_evt);

endmodule : tm2_timer

// File: design/tm2_pkg.sv
/*
 * Constants, field layouts and carrier types shared by the third timer/counter
 * and its machine-cycle phase generator.
 * Assumes the reference clock is the oscillator itself, so one machine cycle
 * spans twelve reference clock cycles.
 */
package tm2_pkg;

    // ------------------------------------------------------------------
    // Special-function addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] TM2_ADDR_CTRL = 8'hc8;
    localparam logic [7:0] TM2_ADDR_MODE = 8'hc9;
    localparam logic [7:0] TM2_ADDR_RCAP_LO = 8'hca;
    localparam logic [7:0] TM2_ADDR_RCAP_HI = 8'hcb;
    localparam logic [7:0] TM2_ADDR_CNT_LO = 8'hcc;
    localparam logic [7:0] TM2_ADDR_CNT_HI = 8'hcd;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] TM2_CTRL_RESET = 8'h00;
    localparam int TM2_MODE_WIDTH = 2;
    localparam logic [TM2_MODE_WIDTH-1:0] TM2_MODE_RESET = 2'h0;
    localparam int TM2_MODE_DOWN_COUNT_ENABLE_BIT = 0;
    localparam int TM2_MODE_OE_BIT = 1;
    localparam logic [15:0] TM2_CNT_MAX = 16'hffff;
    localparam logic [15:0] TM2_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TM2_CNT_ONE = 16'h0001;
    localparam logic [7:0] TM2_BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Machine-cycle timing, phase index = (state - 1) * 2 + (phase - 1)
    // ------------------------------------------------------------------
    localparam int TM2_OSC_PER_MC = 12;
    localparam logic [3:0] TM2_PH_LAST = 4'(TM2_OSC_PER_MC - 1);
    localparam logic [3:0] TM2_PH_FIRST = 4'h0;
    localparam logic [3:0] TM2_PH_S3P1 = 4'h4;
    localparam logic [3:0] TM2_PH_S5P2 = 4'h9;

    // Control register, bit 7 first.
    typedef struct packed {
        logic ovf_flag;
        logic ext_flag;
        logic rx_clk_sel;
        logic tx_clk_sel;
        logic ext_enable;
        logic run;
        logic src_sel;
        logic cap_sel;
    } tm2_ctrl_type;

    // One special-function access from the core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tm2_sfr_req_type;

    // One-cycle timing enables.
    typedef struct packed {
        logic sample;
        logic update;
        logic state;
    } tm2_phase_type;

endpackage : tm2_pkg

// File: design/tm2_phase_gen.sv
/*
 * Machine-cycle phase generator: divides the oscillator clock into the
 * twelve phases of a machine cycle and emits one-cycle enables.
 * Assumes ref_clk is the oscillator and nrst is synchronous, active low.
 */
`timescale 1ns/1ps
module tm2_phase_gen
    import tm2_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    output tm2_phase_type phase
);

    logic [3:0] ph_q;
    logic [3:0] ph_d;
    tm2_phase_type out_q;
    tm2_phase_type out_d;

    // ------------------------------------------------------------------
    // Phase counter and decoded enables
    // ------------------------------------------------------------------

    // Enables are decoded one phase early so they leave a flip-flop.
    always_comb begin
        ph_d = (ph_q == TM2_PH_LAST) ? TM2_PH_FIRST : ph_q + 4'h1;
        out_d.sample = (ph_d == TM2_PH_S5P2);
        out_d.update = (ph_d == TM2_PH_S3P1);
        out_d.state = ph_d[0]; // Second phase of every state time.
    end

    // Registers only.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ph_q <= TM2_PH_FIRST;
            out_q <= '0;
        end else begin
            ph_q <= ph_d;
            out_q <= out_d;
        end
    end

    assign phase = out_q;

endmodule : tm2_phase_gen

// File: bench/tm2_pin_model.sv
/*
 * Far-side model of the count and trigger pins of the third timer.
 * Assumes both pins have pull-ups and that the bench calls the tasks
 * from its main sequence, away from the rising clock edge.
 */
`timescale 1ns/1ps
module tm2_pin_model (
    input wire logic ref_clk,
    input wire logic count_pin_o,
    input wire logic count_pin_oe,
    output logic count_level,
    output logic trigger_level
);
    // ------------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------------
    logic count_drv = 1'b1;

    // A released pin floats up to the pull-up; clock-out wins when enabled.
    assign count_level = count_pin_oe ? count_pin_o : count_drv;
    initial trigger_level = 1'b1;

    // ------------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------------
    // Each level is held two machine cycles, so sync delay never loses one.
    task automatic count_edges(input int n);
        repeat (n) begin
            count_drv = 1'b0;
            repeat (24) @(negedge ref_clk);
            count_drv = 1'b1;
            repeat (24) @(negedge ref_clk);
        end
    endtask : count_edges

    // One falling edge, then a long high so the event lands before we return.
    task automatic trigger_fall();
        trigger_level = 1'b0;
        repeat (24) @(negedge ref_clk);
        trigger_level = 1'b1;
        repeat (36) @(negedge ref_clk);
    endtask : trigger_fall
endmodule : tm2_pin_model

// File: bench/tm2_timer_tb_top.sv
/*
 * Self-checking bench for the third timer: an integer model of the count
 * and reload registers is compared with register reads and pulse counts.
 * Assumes the register access timing and phase behaviour of the hand-over.
 */
`timescale 1ns/1ps
module tm2_timer_tb_top;
    import tm2_pkg::*;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    tm2_sfr_req_type sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic count_level;
    logic trigger_level;
    logic count_pin_o;
    logic count_pin_oe;
    logic timer1_ovf = 1'b0;
    logic t1_en = 1'b0;
    logic timer_irq;
    logic rx_clk_pulse;
    logic tx_clk_pulse;
    logic irq_v;
    logic [7:0] rd_v;
    logic [7:0] rd_ctl;
    logic [7:0] trig_ctl [4] = '{8'h09, 8'h08, 8'h18, 8'h01};
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int rx_seen = 0;
    int tx_seen = 0;
    int t1_seen = 0;
    int cnt;
    int rcap;
    int ovf;
    int n;

    tm2_timer dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .count_pin_i(count_level), .count_pin_o(count_pin_o), .count_pin_oe(count_pin_oe),
        .trigger_pin_i(trigger_level), .timer1_ovf(timer1_ovf), .timer_irq(timer_irq),
        .rx_clk_pulse(rx_clk_pulse), .tx_clk_pulse(tx_clk_pulse));

    tm2_pin_model pins (.ref_clk(ref_clk), .count_pin_o(count_pin_o),
        .count_pin_oe(count_pin_oe), .count_level(count_level),
        .trigger_level(trigger_level));

    // Oscillator clock, 40 ns period.
    initial forever #20 ref_clk = ~ref_clk;

    // Blocking adds keep a same-step clear from the main sequence safe.
    always @(negedge ref_clk) begin
        rx_seen = rx_seen + 32'(rx_clk_pulse);
        tx_seen = tx_seen + 32'(tx_clk_pulse);
        timer1_ovf <= t1_en && ($urandom % 4 == 0);
    end
    always @(posedge ref_clk) t1_seen = t1_seen + 32'(timer1_ovf);

    // A hang is cut short well past the 1400 or so cycles the run needs.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Requests stay up back to back; idle drops them before any wait.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge ref_clk);
        rd_v = sfr_rdata;
    endtask : acc

    task automatic idle(input int k);
        sfr_req = '0;
        repeat (k) @(negedge ref_clk);
    endtask : idle

    task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, rd_v});
    endtask : rd

    task automatic regs();
        rd(TM2_ADDR_CNT_LO, "count_low", cnt[7:0]);
        rd(TM2_ADDR_CNT_HI, "count_high", cnt[15:8]);
        rd(TM2_ADDR_RCAP_LO, "reload_low", rcap[7:0]);
        rd(TM2_ADDR_RCAP_HI, "reload_high", rcap[15:8]);
    endtask : regs

    task automatic load(input logic [15:0] c, input logic [15:0] r);
        cnt = c;
        rcap = r;
        ovf = 0;
        acc(1'b1, TM2_ADDR_CNT_LO, c[7:0]);
        acc(1'b1, TM2_ADDR_CNT_HI, c[15:8]);
        acc(1'b1, TM2_ADDR_RCAP_LO, r[7:0]);
        acc(1'b1, TM2_ADDR_RCAP_HI, r[15:8]);
        idle(1);
    endtask : load

    function automatic void step(input int k);
        repeat (k) begin
            if (cnt == 65535) begin
                cnt = rcap;
                ovf++;
            end else begin
                cnt++;
            end
        end
    endfunction : step

    // Run window of exactly 12*k edges, so the count is phase independent.
    task automatic run(input logic [7:0] c, input int k, input int per);
        acc(1'b1, TM2_ADDR_CTRL, c);
        // Timer 1 pulses only while the selects hold, so no path sees a stray one.
        t1_en = |c[5:4];
        idle(12 * k - 2);
        t1_en = 1'b0;
        irq_v = timer_irq;
        acc(1'b0, TM2_ADDR_CTRL, 8'h00);
        rd_ctl = rd_v;
        acc(1'b1, TM2_ADDR_CTRL, 8'h00);
        idle(2);
        step(12 * k / per);
    endtask : run

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(62326));
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        for (int a = 0; a < 7; a++) rd(8'hc8 + 8'(a), "reset_value", 8'h00);
        acc(1'b1, TM2_ADDR_MODE, 8'hff);
        rd(TM2_ADDR_MODE, "mode_bits", 8'h03);
        acc(1'b1, TM2_ADDR_MODE, 8'h00);
        // Timer function, first pass crossing the top of the count.
        for (int i = 0; i < 3; i++) begin
            load(i == 0 ? 16'hfffe : 16'(($urandom % 32768) | 254), 16'($urandom));
            run(8'h04, 3 + i, 12);
            chk("ctrl_run", ovf > 0 ? 16'h0084 : 16'h0004, {8'h00, rd_ctl});
            chk("irq_ovf", 16'(ovf > 0), {15'h0, irq_v});
            regs();
            idle(30);
            regs();
            rd(TM2_ADDR_CTRL, "flag_clear", 8'h00);
            chk("irq_clear", 16'h0000, {15'h0, timer_irq});
        end
        // Baud generation for transmit, receive and both.
        for (int s = 1; s < 4; s++) begin
            load(16'hffe0 | 16'($urandom % 16), 16'hffe0 | 16'($urandom % 16));
            rx_seen = 0;
            tx_seen = 0;
            t1_seen = 0;
            run(8'h05 | 8'(s << 4), 8, 2);
            idle(3);
            chk("baud_ctrl", {8'h00, 8'h05 | 8'(s << 4)}, {8'h00, rd_ctl});
            chk("tx_pulses", 16'(s[0] ? ovf : t1_seen), 16'(tx_seen));
            chk("rx_pulses", 16'(s[1] ? ovf : t1_seen), 16'(rx_seen));
            regs();
        end
        // Clock-out: the pin toggles on each overflow and the flag stays clear.
        acc(1'b1, TM2_ADDR_MODE, 8'h02);
        load(16'hffe0 | 16'($urandom % 16), 16'hffe0 | 16'($urandom % 16));
        run(8'h04, 8, 2);
        chk("clkout_ctrl", 16'h0004, {8'h00, rd_ctl});
        chk("clkout_pin", {15'h0, ovf[0]}, {15'h0, count_pin_o});
        chk("clkout_oe", 16'h0001, {15'h0, count_pin_oe});
        regs();
        acc(1'b1, TM2_ADDR_MODE, 8'h00);
        // Trigger edge under capture, reload, baud and disabled settings.
        foreach (trig_ctl[j]) begin
            load(16'($urandom), 16'($urandom));
            acc(1'b1, TM2_ADDR_CTRL, trig_ctl[j]);
            idle(1);
            pins.trigger_fall();
            if (trig_ctl[j] == 8'h09) rcap = cnt;
            if (trig_ctl[j] == 8'h08) cnt = rcap;
            rd(TM2_ADDR_CTRL, "ext_flag", trig_ctl[j] | {1'b0, trig_ctl[j][3], 6'h00});
            chk("irq_ext", {15'h0, trig_ctl[j][3]}, {15'h0, timer_irq});
            regs();
            acc(1'b1, TM2_ADDR_CTRL, 8'h00);
            idle(1);
        end
        // Up/down counting with the trigger pin low counts down to the reload value.
        acc(1'b1, TM2_ADDR_MODE, 8'h01);
        pins.trigger_level = 1'b0;
        idle(24);
        load(16'h0011 + 16'($urandom % 4), 16'h0010);
        n = cnt;
        run(8'h04, 8, 12);
        cnt = n;
        repeat (8) cnt = (cnt == rcap) ? 65535 : cnt - 1;
        chk("down_ctrl", 16'h00c4, {8'h00, rd_ctl});
        regs();
        pins.trigger_level = 1'b1;
        acc(1'b1, TM2_ADDR_MODE, 8'h00);
        idle(24);
        // Counter function: only pin edges advance the count.
        load(16'($urandom), 16'($urandom));
        acc(1'b1, TM2_ADDR_CTRL, 8'h06);
        idle(1);
        n = 2 + $urandom % 3;
        pins.count_edges(n);
        acc(1'b1, TM2_ADDR_CTRL, 8'h00);
        idle(2);
        step(n);
        regs();
        test_done();
    end
endmodule : tm2_timer_tb_top
